// ### shared/swel_map.svh
// Constants for the serial memory write-enable latch block.
`ifndef SWEL_MAP_SVH
`define SWEL_MAP_SVH
`define SWEL_OP_SET_WE      8'h06
`define SWEL_OP_CLR_WE      8'h04
`define SWEL_OP_RD_STATUS   8'h05
`define SWEL_OP_WR_STATUS   8'h01
`define SWEL_OP_WRITE_LO    8'h02
`define SWEL_OP_WRITE_HI    8'h0a
`define SWEL_OP_READ_LO     8'h03
`define SWEL_OP_READ_HI     8'h0b
`define SWEL_OP_ADDR_BIT    3
`define SWEL_SR_WEL_BIT     1
`define SWEL_SR_BP_LO_BIT   2
`define SWEL_SR_BP_HI_BIT   3
`define SWEL_SR_RESET       8'h00
`define SWEL_ADDR_WIDTH     9
`define SWEL_MEM_DEPTH      512
`endif

// ### shared/swel_pkg.sv
// Types for the serial memory write-enable latch block.
package swel_pkg;
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_ADDR   = 3'b001,
		ST_WDATA  = 3'b010,
		ST_RDATA  = 3'b011,
		ST_SRDATA = 3'b100,
		ST_IDLE   = 3'b101
	} swel_state_t;
	typedef struct packed {
		logic       csActive;
		logic       sckRise;
		logic       sckFall;
		logic       mosi;
	} swel_pins_t;
endpackage

// ### src/swel_pin_sync.sv
// Pin synchroniser and SPI clock edge finder.
`timescale 1ns/10ps
module swel_pin_sync
	import swel_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Raw pins.
	input  wire logic       sck,
	input  wire logic       csN,
	input  wire logic       mosi,
	// Cleaned pin events.
	output swel_pins_t      pins
);
	logic [2:0] s1;
	logic [2:0] s2;
	logic       sckOld;
	logic [2:0] next_s1;
	logic [2:0] next_s2;
	logic       next_sckOld;

	always_comb begin
		next_s1     = {sck, csN, mosi};
		next_s2     = s1;
		next_sckOld = s2[2];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1     <= 3'h3;
			s2     <= 3'h3;
			sckOld <= 1'b0;
		end else begin
			s1     <= next_s1;
			s2     <= next_s2;
			sckOld <= next_sckOld;
		end
	end

	assign pins.csActive = ~s2[1];
	assign pins.sckRise  = s2[2] & ~sckOld & ~s2[1];
	assign pins.sckFall  = ~s2[2] & sckOld & ~s2[1];
	assign pins.mosi     = s2[0];
endmodule // swel_pin_sync

// ### src/swel_core.sv
// Serial memory command decoder with write-enable latch and status register.
//
// Contract
// - Set-write-enable command sets the write-enable latch.
// - Status bit 1 always shows the write-enable latch.
// - Array or status writes happen only while the latch is one.
// - Status write data never writes the latch bit.
// - Completing a write clears the latch, except an upper-half memory write.
// - Clearing follows lower-half memory write and status write commands.
// - Upper-half memory write opcode leaves the latch set.
// - After upper-half write, a following write is accepted without re-enabling.
// - Latch is zero after reset.
// - Status bit 0 always reads zero.
// - Status bits 4 to 7 always read zero.
// - Status bits 2 and 3 are block-protect bits, zero at reset.
// - Array is 512 bytes with 9-bit address.
// - Write opcode bit 3 is address bit 8; 0x02 lower, 0x0A upper.
// - Read opcode bit 3 is address bit 8; 0x03 lower, 0x0B upper.
// - Clear-write-enable command clears the latch.
`timescale 1ns/10ps
`include "swel_map.svh"
module swel_core
	import swel_pkg::*;
#(
	parameter int ADDR_WIDTH = `SWEL_ADDR_WIDTH,
	parameter int MEM_DEPTH  = `SWEL_MEM_DEPTH
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_b,
	// SPI pins from the host.
	input  wire logic       sck,
	input  wire logic       csN,
	input  wire logic       mosi,
	// Serial data out, two signals.
	output logic            misoOut,
	output logic            misoOe_b,
	// Status register view.
	output logic [7:0]      deviceStatus
);
	swel_pins_t pins;

	swel_pin_sync u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.sck   (sck),
		.csN   (csN),
		.mosi  (mosi),
		.pins  (pins)
	);

	logic [7:0] mem [MEM_DEPTH];

	swel_state_t            state;
	logic [7:0]             shiftIn;
	logic [2:0]             bitCnt;
	logic [7:0]             opcode;
	logic [ADDR_WIDTH-1:0]  addr;
	logic [7:0]             shiftOut;
	logic                   writeEnableLatch;
	logic                   blockProtectLow;
	logic                   blockProtectHigh;
	logic                   clearPending;
	logic                   csWas;
	logic                   misoOutQ;
	logic                   misoOeQ_b;
	logic [7:0]             statusQ;

	swel_state_t            next_state;
	logic [7:0]             next_shiftIn;
	logic [2:0]             next_bitCnt;
	logic [7:0]             next_opcode;
	logic [ADDR_WIDTH-1:0]  next_addr;
	logic [7:0]             next_shiftOut;
	logic                   next_writeEnableLatch;
	logic                   next_blockProtectLow;
	logic                   next_blockProtectHigh;
	logic                   next_clearPending;
	logic                   next_misoOut;
	logic                   next_misoOe_b;
	logic [7:0]             next_status;
	logic                   memWrite;
	logic [7:0]             byteIn;
	logic                   byteDone;
	logic                   csEnd;
	logic [7:0]             statusNow;

	always_comb begin
		statusNow = 8'h00;
		statusNow[`SWEL_SR_WEL_BIT]   = writeEnableLatch;
		statusNow[`SWEL_SR_BP_LO_BIT] = blockProtectLow;
		statusNow[`SWEL_SR_BP_HI_BIT] = blockProtectHigh;
	end

	always_comb begin
		next_state            = state;
		next_shiftIn          = shiftIn;
		next_bitCnt           = bitCnt;
		next_opcode           = opcode;
		next_addr             = addr;
		next_shiftOut         = shiftOut;
		next_writeEnableLatch = writeEnableLatch;
		next_blockProtectLow  = blockProtectLow;
		next_blockProtectHigh = blockProtectHigh;
		next_clearPending     = clearPending;
		next_misoOut          = misoOutQ;
		next_misoOe_b         = misoOeQ_b;
		memWrite              = 1'b0;
		byteIn                = {shiftIn[6:0], pins.mosi};
		byteDone              = pins.sckRise && (bitCnt == 3'h7);
		csEnd                 = csWas && !pins.csActive;
		if (!pins.csActive) begin
			next_state    = ST_OPCODE;
			next_bitCnt   = 3'h0;
			next_misoOe_b = 1'b1;
			if (csEnd && clearPending) begin
				next_writeEnableLatch = 1'b0;
				next_clearPending     = 1'b0;
			end
		end else begin
			if (pins.sckRise) begin
				next_shiftIn = byteIn;
				next_bitCnt  = bitCnt + 3'h1;
			end
			if (pins.sckFall && (state == ST_RDATA ||
					(state == ST_SRDATA && opcode == `SWEL_OP_RD_STATUS))) begin
				next_misoOut  = shiftOut[7];
				next_shiftOut = {shiftOut[6:0], 1'b0};
				next_misoOe_b = 1'b0;
			end
			if (byteDone) begin
				case (state)
					ST_OPCODE: begin
						next_opcode = byteIn;
						next_addr   = '0;
						next_addr[ADDR_WIDTH-1] = byteIn[`SWEL_OP_ADDR_BIT];
						if (byteIn == `SWEL_OP_SET_WE) begin
							next_writeEnableLatch = 1'b1;
							next_clearPending     = 1'b0;
							next_state            = ST_IDLE;
						end else if (byteIn == `SWEL_OP_CLR_WE) begin
							next_writeEnableLatch = 1'b0;
							next_clearPending     = 1'b0;
							next_state            = ST_IDLE;
						end else if (byteIn == `SWEL_OP_RD_STATUS) begin
							next_shiftOut = statusNow;
							next_state    = ST_SRDATA;
						end else if (byteIn == `SWEL_OP_WR_STATUS) begin
							next_state = ST_SRDATA;
						end else if (byteIn == `SWEL_OP_WRITE_LO || byteIn == `SWEL_OP_WRITE_HI ||
								byteIn == `SWEL_OP_READ_LO || byteIn == `SWEL_OP_READ_HI) begin
							next_state = ST_ADDR;
						end else begin
							next_state = ST_IDLE;
						end
					end
					ST_ADDR: begin
						next_addr[7:0] = byteIn;
						if (opcode[0]) begin
							next_shiftOut = mem[{addr[ADDR_WIDTH-1], byteIn}];
							next_state    = ST_RDATA;
						end else begin
							next_state = ST_WDATA;
						end
					end
					ST_WDATA: begin
						if (writeEnableLatch) begin
							memWrite  = 1'b1;
							next_addr = addr + ADDR_WIDTH'(1);
							if (opcode != `SWEL_OP_WRITE_HI) begin
								next_clearPending = 1'b1;
							end
						end
					end
					ST_RDATA: begin
						next_addr     = addr + ADDR_WIDTH'(1);
						next_shiftOut = mem[addr + ADDR_WIDTH'(1)];
					end
					ST_SRDATA: begin
						if (opcode == `SWEL_OP_WR_STATUS && writeEnableLatch) begin
							next_blockProtectLow  = byteIn[`SWEL_SR_BP_LO_BIT];
							next_blockProtectHigh = byteIn[`SWEL_SR_BP_HI_BIT];
							next_clearPending     = 1'b1;
						end else begin
							next_shiftOut = statusNow;
						end
					end
					default: next_state = ST_IDLE;
				endcase
			end
		end
		next_status = statusNow;
	end

	always_ff @(posedge clk) begin
		if (memWrite) begin
			mem[addr] <= byteIn;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state            <= ST_OPCODE;
			shiftIn          <= 8'h00;
			bitCnt           <= 3'h0;
			opcode           <= 8'h00;
			addr             <= '0;
			shiftOut         <= 8'h00;
			writeEnableLatch <= 1'b0;
			blockProtectLow  <= 1'b0;
			blockProtectHigh <= 1'b0;
			clearPending     <= 1'b0;
			csWas            <= 1'b0;
			misoOutQ         <= 1'b0;
			misoOeQ_b        <= 1'b1;
			statusQ          <= `SWEL_SR_RESET;
		end else begin
			state            <= next_state;
			shiftIn          <= next_shiftIn;
			bitCnt           <= next_bitCnt;
			opcode           <= next_opcode;
			addr             <= next_addr;
			shiftOut         <= next_shiftOut;
			writeEnableLatch <= next_writeEnableLatch;
			blockProtectLow  <= next_blockProtectLow;
			blockProtectHigh <= next_blockProtectHigh;
			clearPending     <= next_clearPending;
			csWas            <= pins.csActive;
			misoOutQ         <= next_misoOut;
			misoOeQ_b        <= next_misoOe_b;
			statusQ          <= next_status;
		end
	end

	assign misoOut      = misoOutQ;
	assign misoOe_b     = misoOeQ_b;
	assign deviceStatus = statusQ;

	a_status_zero_bits: assert property (@(posedge clk) disable iff (!rst_b)
		deviceStatus[0] == 1'b0) else $error("Status bit 0 not zero.");
	a_status_high_bits: assert property (@(posedge clk) disable iff (!rst_b)
		deviceStatus[7:4] == 4'h0) else $error("Status high bits not zero.");
	a_status_tracks_wel: assert property (@(posedge clk) disable iff (!rst_b)
		deviceStatus[1] == $past(writeEnableLatch)) else $error("Status bit 1 differs from latch.");
	a_set_we_sets: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_OPCODE && byteIn == `SWEL_OP_SET_WE |=> writeEnableLatch)
		else $error("Set command did not set latch.");
	a_clr_we_clears: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_OPCODE && byteIn == `SWEL_OP_CLR_WE |=> !writeEnableLatch)
		else $error("Clear command did not clear latch.");
	a_write_gated: assert property (@(posedge clk) disable iff (!rst_b)
		memWrite |-> writeEnableLatch) else $error("Array written with latch clear.");
	a_clear_at_cs: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(writeEnableLatch) |-> $past(csEnd) || $past(byteDone))
		else $error("Latch fell outside command end.");
	a_hi_write_keeps: assert property (@(posedge clk) disable iff (!rst_b)
		memWrite && opcode == `SWEL_OP_WRITE_HI && !clearPending |=> !clearPending)
		else $error("Upper write armed latch clear.");
	a_lo_write_arms: assert property (@(posedge clk) disable iff (!rst_b)
		memWrite && opcode == `SWEL_OP_WRITE_LO |=> clearPending)
		else $error("Lower write did not arm clear.");
	a_bp_gated: assert property (@(posedge clk) disable iff (!rst_b)
		!writeEnableLatch && !$past(writeEnableLatch) |-> $stable(blockProtectLow) && $stable(blockProtectHigh))
		else $error("Block protect changed while disabled.");

	a_sr_write_arms: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_SRDATA && opcode == `SWEL_OP_WR_STATUS && writeEnableLatch |=> clearPending)
		else $error("Status write did not arm clear.");
	a_cs_end_clears: assert property (@(posedge clk) disable iff (!rst_b)
		csEnd && clearPending |=> !writeEnableLatch)
		else $error("Latch not cleared at command end.");
	a_sr_keeps_latch: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_SRDATA && opcode == `SWEL_OP_WR_STATUS |=> $stable(writeEnableLatch))
		else $error("Status write changed latch.");
	a_refused_status: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_SRDATA && opcode == `SWEL_OP_WR_STATUS && !writeEnableLatch
		|=> $stable(blockProtectLow) && $stable(blockProtectHigh))
		else $error("Refused status write took effect.");
	a_refused_no_arm: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_WDATA && !writeEnableLatch && !clearPending |=> !clearPending)
		else $error("Refused write armed latch clear.");
	a_hi_write_latch: assert property (@(posedge clk) disable iff (!rst_b)
		memWrite && opcode == `SWEL_OP_WRITE_HI |=> writeEnableLatch)
		else $error("Upper write dropped latch.");
	a_write_hi_bit: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_OPCODE && byteIn == `SWEL_OP_WRITE_HI |=> addr[ADDR_WIDTH-1])
		else $error("Upper write opcode lost address bit.");
	a_read_hi_bit: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_OPCODE && byteIn == `SWEL_OP_READ_HI |=> addr[ADDR_WIDTH-1])
		else $error("Upper read opcode lost address bit.");
	a_lo_addr_bit: assert property (@(posedge clk) disable iff (!rst_b)
		byteDone && state == ST_OPCODE && (byteIn == `SWEL_OP_WRITE_LO || byteIn == `SWEL_OP_READ_LO)
		|=> !addr[ADDR_WIDTH-1])
		else $error("Lower opcode set address bit.");
	a_reset_clears_wel: assert property (@(posedge clk)
		$rose(rst_b) |-> !writeEnableLatch && deviceStatus == `SWEL_SR_RESET && misoOe_b)
		else $error("Reset left latch or status set.");
	a_status_bp: assert property (@(posedge clk) disable iff (!rst_b)
		deviceStatus[3] == $past(blockProtectHigh) && deviceStatus[2] == $past(blockProtectLow))
		else $error("Status block-protect bits differ.");
endmodule // swel_core

// ### testbench/swel_spi_host.sv
// SPI host model that frames commands and shifts bytes in mode 0.
`timescale 1ns/10ps
module swel_spi_host (
	// Clock.
	input  wire logic clk,
	// SPI pins.
	output logic      sck,
	output logic      csN,
	output logic      mosi,
	input  wire logic misoOut,
	input  wire logic misoOe_b
);
	initial begin
		sck  = 1'b0;
		csN  = 1'b1;
		mosi = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic sel();
		half();
		csN = 1'b0;
		half();
	endtask
	// Data is set while the clock is low and read just before it falls.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			half();
			sck = 1'b1;
			half();
			rx[i] = misoOe_b ? ~misoOut : misoOut;
			sck = 1'b0;
		end
	endtask
	// The data line shows the inverse of its last value once released.
	task automatic desel();
		half();
		csN  = 1'b1;
		mosi = ~mosi;
		half();
		half();
		half();
	endtask
endmodule // swel_spi_host

// ### testbench/tb_top.sv
// Self-checking bench for the write-enable latch and status register.
`timescale 1ns/10ps
`include "swel_map.svh"
module tb_top;
	logic       clk;
	logic       rst_b;
	logic       sck;
	logic       csN;
	logic       mosi;
	logic       misoOut;
	logic       misoOe_b;
	logic [7:0] deviceStatus;
	logic [7:0] rx;
	int         bad_count;
	int         checks_done;

	swel_core u_dut (.clk(clk), .rst_b(rst_b), .sck(sck), .csN(csN), .mosi(mosi),
		.misoOut(misoOut), .misoOe_b(misoOe_b), .deviceStatus(deviceStatus));
	swel_spi_host u_host (.clk(clk), .sck(sck), .csN(csN), .mosi(mosi),
		.misoOut(misoOut), .misoOe_b(misoOe_b));

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op);
		u_host.sel();
		u_host.xfer(op, rx);
		u_host.desel();
	endtask
	// Status is looked at after the last byte while the frame is still open.
	task automatic wr(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d, input logic [7:0] mid);
		u_host.sel();
		u_host.xfer(op, rx);
		if (op != `SWEL_OP_WR_STATUS) u_host.xfer(a, rx);
		u_host.xfer(d, rx);
		u_host.half();
		u_host.half();
		chk("statusInFrame", deviceStatus, mid);
		u_host.desel();
	endtask
	task automatic rd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] exp);
		u_host.sel();
		u_host.xfer(op, rx);
		if (op != `SWEL_OP_RD_STATUS) u_host.xfer(a, rx);
		u_host.xfer(8'h00, rx);
		u_host.desel();
		chk("readData", rx, exp);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#500000;
		bad_count++;
		conclude();
	end
	initial begin
		rst_b       = 1'b0;
		bad_count   = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("resetStatus", deviceStatus, 8'h00);
		chk("misoIdle", {7'h00, misoOe_b}, 8'h01);
		rd(`SWEL_OP_RD_STATUS, 8'h00, 8'h00);
		cmd(`SWEL_OP_SET_WE);
		chk("latchSet", deviceStatus, 8'h02);
		rd(`SWEL_OP_RD_STATUS, 8'h00, 8'h02);
		wr(`SWEL_OP_WRITE_LO, 8'h10, 8'ha5, 8'h02);
		chk("lowWriteClears", deviceStatus, 8'h00);
		wr(`SWEL_OP_WRITE_LO, 8'h10, 8'h5a, 8'h00);
		rd(`SWEL_OP_READ_LO, 8'h10, 8'ha5);
		cmd(`SWEL_OP_SET_WE);
		wr(`SWEL_OP_WRITE_HI, 8'h10, 8'h3c, 8'h02);
		chk("highWriteKeeps", deviceStatus, 8'h02);
		wr(`SWEL_OP_WRITE_LO, 8'h10, 8'hc3, 8'h02);
		chk("lowWriteClears", deviceStatus, 8'h00);
		rd(`SWEL_OP_READ_LO, 8'h10, 8'hc3);
		rd(`SWEL_OP_READ_HI, 8'h10, 8'h3c);
		cmd(`SWEL_OP_SET_WE);
		wr(`SWEL_OP_WRITE_HI, 8'h20, 8'h11, 8'h02);
		wr(`SWEL_OP_WR_STATUS, 8'h00, 8'hfd, 8'h0e);
		chk("statusWriteClears", deviceStatus, 8'h0c);
		rd(`SWEL_OP_RD_STATUS, 8'h00, 8'h0c);
		wr(`SWEL_OP_WR_STATUS, 8'h00, 8'h00, 8'h0c);
		chk("refusedStatus", deviceStatus, 8'h0c);
		cmd(`SWEL_OP_SET_WE);
		chk("latchSetAgain", deviceStatus, 8'h0e);
		cmd(`SWEL_OP_CLR_WE);
		chk("latchCleared", deviceStatus, 8'h0c);
		cmd(`SWEL_OP_CLR_WE);
		chk("clearIdempotent", deviceStatus, 8'h0c);
		rst_b = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("midRunReset", deviceStatus, 8'h00);
		rst_b = 1'b1;
		repeat (4) @(posedge clk);
		rd(`SWEL_OP_RD_STATUS, 8'h00, 8'h00);
		wr(`SWEL_OP_WRITE_HI, 8'h20, 8'h77, 8'h00);
		rd(`SWEL_OP_READ_HI, 8'h20, 8'h11);
		conclude();
	end
endmodule // tb_top
